// [include/cbe_pkg.sv]
// Package with the register map, field positions and carrier types of the break-event enables.
package cbe_pkg;
   // Printed offsets are register indices; the byte address is four times the index.
   localparam logic [9:0]  IDX_ENABLE_A   = 10'h0E6;
   localparam logic [9:0]  IDX_ENABLE_B   = 10'h0E7;
   localparam logic [9:0]  IDX_WDT_BASE   = 10'h0E8;
   localparam logic [11:0] ADDR_ENABLE_A  = {IDX_ENABLE_A, 2'h0};
   localparam logic [11:0] ADDR_ENABLE_B  = {IDX_ENABLE_B, 2'h0};
   localparam logic [11:0] ADDR_WDT_BASE  = {IDX_WDT_BASE, 2'h0};
   localparam int          ADDR_W         = 12;

   localparam logic [7:0]  RST_ENABLE_A   = 8'h00;
   localparam logic [7:0]  RST_ENABLE_B   = 8'h00;
   localparam logic [23:0] RST_WDT_BASE   = 24'h000000;
   localparam logic [7:0]  WDT_LOW_ZERO   = 8'h00;

   // First enable byte.
   localparam int A_IDE   = 7;
   localparam int A_USBD  = 6;
   localparam int A_PCI   = 5;
   localparam int A_CARD  = 4;
   localparam int A_AUX   = 3;
   localparam int A_EHCI  = 2;
   localparam int A_UHCI  = 1;
   localparam int A_AUDIO = 0;
   // Second enable byte.
   localparam int B_APIC      = 7;
   localparam int B_FIFO      = 6;
   localparam int B_PLAY_INH  = 5;
   localparam int B_REC_INH   = 4;
   localparam int B_RING_PTR  = 3;
   localparam int B_RING_RUN  = 2;
   localparam int B_REC_RUN   = 1;
   localparam int B_PLAY_RUN  = 0;

   typedef struct packed {
      logic ide;
      logic usb_device;
      logic pci;
      logic card_reader;
      logic auxiliary_bus_master;
      logic ehci;
      logic uhci;
      logic audio_dma;
   } cbe_src_s;

   typedef struct packed {
      logic apic_cycle;
      logic record_fifo_not_empty;
      logic play_run;
      logic record_run;
      logic ring_ptr_mismatch;
      logic ring_run;
   } cbe_audio_s;
endpackage

// [hdl/cbe_enables.sv]
// Break-event enable registers, watchdog memory base and the break-event combining logic.
//
// Contract
// - Enable-A bit 7 makes parallel disk bus master activity a break event.
// - Enable-A bit 6 makes USB device-mode bus mastering a break event.
// - Enable-A bit 5 makes external PCI bus master activity a break event.
// - Enable-A bit 4 makes card reader activity a break event.
// - Enable-A bit 3 makes auxiliary bus master activity a break event.
// - Enable-A bits 2 and 1 make EHCI and UHCI activity break events.
// - Enable-A bit 0 enables audio/DMA breaks and gates every audio reflect option.
// - Enable-B bit 7 lets interrupt-controller cycles drive all-bus-master activity.
// - Enable-B bit 6 reflects non-empty record FIFO into audio DMA activity.
// - Enable-B bit 5 lets a running playback block the deepest sleep state.
// - Enable-B bit 4 lets a running record block the deepest sleep state.
// - Enable-B bit 3 reflects ring pointer mismatch into audio DMA activity.
// - Enable-B bit 2 reflects the ring run bit into audio DMA activity.
// - Enable-B bit 1 reflects the record run bit into audio DMA activity.
// - Enable-B bit 0 reflects the playback run bit into audio DMA activity.
// - Reflected audio run bits also show in the bus-master status bit.
// - Watchdog base keeps bits 31:8 writable; bits 7:0 read zero.
// - Both enable bytes reset to zero.
// - Watchdog memory base resets to zero.
module cbe_enables (
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             ce,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [cbe_pkg::ADDR_W-1:0]       paddr,
   input  wire logic [31:0]                      pwdata,
   input  wire logic [3:0]                       pstrb,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire cbe_pkg::cbe_src_s                src_active,
   input  wire cbe_pkg::cbe_audio_s              audio_state,
   output logic                                  cx_break_event,
   output logic                                  all_bm_active,
   output logic                                  audio_dma_active,
   output logic                                  bm_status_audio,
   output logic                                  deepest_sleep_inhibit,
   output logic      [31:0]                      wdt_mem_base
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers and bus decode.

   logic [7:0]  enable_a_r;
   logic [7:0]  enable_b_r;
   wire [23:0]  wdt_base_r;
   logic [31:0] prdata_r;
   logic        hit_r;

   wire sel_a      = (paddr == cbe_pkg::ADDR_ENABLE_A);
   wire sel_b      = (paddr == cbe_pkg::ADDR_ENABLE_B);
   wire sel_w      = (paddr == cbe_pkg::ADDR_WDT_BASE);
   wire addr_hit   = sel_a | sel_b | sel_w;
   wire setup_ph   = ce & psel & ~penable;
   wire access_ph  = ce & psel & penable;
   wire wr_commit  = access_ph & pwrite & hit_r;
   wire wr_a       = wr_commit & sel_a & pstrb[0];
   wire wr_b       = wr_commit & sel_b & pstrb[0];

   // Reads are captured in the setup cycle, so the answer never waits a cycle.
   wire [31:0] rd_mux = sel_a ? {24'h000000, enable_a_r} :
                        sel_b ? {24'h000000, enable_b_r} :
                        sel_w ? {wdt_base_r, cbe_pkg::WDT_LOW_ZERO} : 32'h00000000;

   assign pready  = access_ph;
   assign pslverr = access_ph & ~hit_r;
   assign prdata  = prdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
         hit_r    <= 1'b0;
      end else if (setup_ph) begin
         prdata_r <= pwrite ? 32'h00000000 : rd_mux;
         hit_r    <= addr_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_a_r <= cbe_pkg::RST_ENABLE_A;
         enable_b_r <= cbe_pkg::RST_ENABLE_B;
      end else begin
         if (wr_a) begin
            enable_a_r <= pwdata[7:0];
         end
         if (wr_b) begin
            enable_b_r <= pwdata[7:0];
         end
      end
   end

   // Byte lanes one to three cover the writable base bits; lane zero is hardwired.
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_wdt_lane
         cbe_byte_lane #(
            .RST_VAL (cbe_pkg::RST_WDT_BASE[g*8 +: 8])
         ) u_lane (
            .pclk    (pclk),
            .presetn (presetn),
            .wr_en   (wr_commit & sel_w & pstrb[g+1]),
            .wr_data (pwdata[(g+1)*8 +: 8]),
            .lane_r  (wdt_base_r[g*8 +: 8])
         );
      end
   endgenerate

   assign wdt_mem_base = {wdt_base_r, cbe_pkg::WDT_LOW_ZERO};

   ////////////////////////////////////////////////////////////////////////////
   // Break-event combining.

   wire aud_gate = enable_a_r[cbe_pkg::A_AUDIO];

   wire refl_fifo = enable_b_r[cbe_pkg::B_FIFO] & audio_state.record_fifo_not_empty;
   wire refl_ptr  = enable_b_r[cbe_pkg::B_RING_PTR] & audio_state.ring_ptr_mismatch;
   wire refl_ring = enable_b_r[cbe_pkg::B_RING_RUN] & audio_state.ring_run;
   wire refl_rec  = enable_b_r[cbe_pkg::B_REC_RUN] & audio_state.record_run;
   wire refl_play = enable_b_r[cbe_pkg::B_PLAY_RUN] & audio_state.play_run;

   // Run-bit and ring pointer mismatch reflections are what the status bit reports; the FIFO level is not.
   wire run_refl  = aud_gate & (refl_ptr | refl_ring | refl_rec | refl_play);
   wire dma_nxt   = aud_gate & (src_active.audio_dma | refl_fifo | run_refl);

   wire [7:0] src_vec = {src_active.ide, src_active.usb_device, src_active.pci,
                         src_active.card_reader, src_active.auxiliary_bus_master,
                         src_active.ehci, src_active.uhci, dma_nxt};
   wire [7:0] hit_vec = enable_a_r & src_vec;
   wire break_nxt     = |hit_vec;
   wire apic_nxt      = enable_b_r[cbe_pkg::B_APIC] & audio_state.apic_cycle;
   wire all_bm_nxt    = break_nxt | apic_nxt;
   wire inhibit_nxt   = (enable_b_r[cbe_pkg::B_PLAY_INH] & audio_state.play_run) |
                        (enable_b_r[cbe_pkg::B_REC_INH] & audio_state.record_run);

   // Outputs are registered so the sequencer sees glitch-free levels, at one cycle of latency.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cx_break_event        <= 1'b0;
         all_bm_active         <= 1'b0;
         audio_dma_active      <= 1'b0;
         bm_status_audio       <= 1'b0;
         deepest_sleep_inhibit <= 1'b0;
      end else if (ce) begin
         cx_break_event        <= break_nxt;
         all_bm_active         <= all_bm_nxt;
         audio_dma_active      <= dma_nxt;
         bm_status_audio       <= run_refl;
         deepest_sleep_inhibit <= inhibit_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_write_a;
      ce && psel && !penable && pwrite && sel_a && pstrb[0];
   endsequence

   sequence s_access;
      ce && psel && penable;
   endsequence

   a_enable_a_write: assert property (
      s_write_a ##1 s_access |=> enable_a_r == $past(pwdata[7:0]))
      else $error("Enable A did not take the written byte.");

   a_ide_break: assert property (
      ce && enable_a_r[cbe_pkg::A_IDE] && src_active.ide |=> cx_break_event)
      else $error("Enabled disk activity did not raise a break.");

   a_break_or: assert property (
      ce |=> cx_break_event == |($past(enable_a_r) & $past(src_vec)))
      else $error("Break event differs from enabled sources.");

   a_no_break_off: assert property (
      ce && enable_a_r == 8'h00 |=> !cx_break_event)
      else $error("Break raised with all sources disabled.");

   a_audio_gate: assert property (
      ce && !enable_a_r[cbe_pkg::A_AUDIO] |=> !audio_dma_active && !bm_status_audio)
      else $error("Audio reflect passed with audio break disabled.");

   a_fifo_reflect: assert property (
      ce && aud_gate && enable_b_r[cbe_pkg::B_FIFO] && audio_state.record_fifo_not_empty
      |=> audio_dma_active && cx_break_event)
      else $error("Record FIFO level not reflected.");

   a_play_status: assert property (
      ce && aud_gate && refl_play |=> bm_status_audio && audio_dma_active)
      else $error("Reflected playback run missing from status.");

   a_apic_all: assert property (
      ce && apic_nxt |=> all_bm_active)
      else $error("Interrupt cycle not reflected into all-master activity.");

   a_inhibit: assert property (
      ce |=> deepest_sleep_inhibit == $past(inhibit_nxt))
      else $error("Deepest-state inhibit wrong.");

   a_wdt_low_zero: assert property (
      wdt_mem_base[7:0] == 8'h00)
      else $error("Watchdog base low byte not zero.");

   a_unmapped_err: assert property (
      ce && psel && !penable && !addr_hit ##1 s_access |-> pslverr && pready)
      else $error("Unmapped access not refused.");

   sequence s_write_b;
      ce && psel && !penable && pwrite && sel_b && pstrb[0];
   endsequence

   sequence s_write_w;
      ce && psel && !penable && pwrite && sel_w && pstrb == 4'hF;
   endsequence

   a_enable_b_write: assert property (
      s_write_b ##1 s_access |=> enable_b_r == $past(pwdata[7:0]))
      else $error("Enable B did not take the written byte.");

   a_wdt_write: assert property (
      s_write_w ##1 s_access |=> wdt_mem_base[31:8] == $past(pwdata[31:8]))
      else $error("Watchdog base did not take the written bits.");

   a_base_read_low: assert property (
      ce && psel && !penable && !pwrite && sel_w |=> prdata[7:0] == 8'h00)
      else $error("Watchdog base low byte read back non-zero.");

   a_usbd_break: assert property (
      ce && enable_a_r[cbe_pkg::A_USBD] && src_active.usb_device |=> cx_break_event)
      else $error("Enabled USB device activity did not raise a break.");

   a_pci_break: assert property (
      ce && enable_a_r[cbe_pkg::A_PCI] && src_active.pci |=> cx_break_event)
      else $error("Enabled PCI master activity did not raise a break.");

   a_card_break: assert property (
      ce && enable_a_r[cbe_pkg::A_CARD] && src_active.card_reader |=> cx_break_event)
      else $error("Enabled card reader activity did not raise a break.");

   a_aux_break: assert property (
      ce && enable_a_r[cbe_pkg::A_AUX] && src_active.auxiliary_bus_master |=> cx_break_event)
      else $error("Enabled auxiliary master activity did not raise a break.");

   a_ehci_break: assert property (
      ce && enable_a_r[cbe_pkg::A_EHCI] && src_active.ehci |=> cx_break_event)
      else $error("Enabled EHCI activity did not raise a break.");

   a_uhci_break: assert property (
      ce && enable_a_r[cbe_pkg::A_UHCI] && src_active.uhci |=> cx_break_event)
      else $error("Enabled UHCI activity did not raise a break.");

   a_dma_source: assert property (
      ce && aud_gate && src_active.audio_dma |=> audio_dma_active && cx_break_event)
      else $error("Enabled audio DMA activity did not raise a break.");

   a_dma_break: assert property (
      audio_dma_active |-> cx_break_event)
      else $error("Audio DMA activity without a break event.");

   a_ptr_reflect: assert property (
      ce && aud_gate && enable_b_r[cbe_pkg::B_RING_PTR] && audio_state.ring_ptr_mismatch
      |=> audio_dma_active && bm_status_audio)
      else $error("Ring pointer mismatch not reflected.");

   a_ring_reflect: assert property (
      ce && aud_gate && enable_b_r[cbe_pkg::B_RING_RUN] && audio_state.ring_run
      |=> audio_dma_active && bm_status_audio)
      else $error("Ring run bit not reflected.");

   a_rec_reflect: assert property (
      ce && aud_gate && enable_b_r[cbe_pkg::B_REC_RUN] && audio_state.record_run
      |=> audio_dma_active && bm_status_audio)
      else $error("Record run bit not reflected.");

   a_play_reflect: assert property (
      ce && aud_gate && enable_b_r[cbe_pkg::B_PLAY_RUN] && audio_state.play_run
      |=> audio_dma_active)
      else $error("Playback run bit not reflected.");

   a_status_dma: assert property (
      bm_status_audio |-> audio_dma_active)
      else $error("Status bit set without audio DMA activity.");

   a_apic_only: assert property (
      ce && !enable_b_r[cbe_pkg::B_APIC] |=> all_bm_active == cx_break_event)
      else $error("All-master activity differs from break with interrupt reflect off.");

   a_play_inhibit: assert property (
      ce && enable_b_r[cbe_pkg::B_PLAY_INH] && audio_state.play_run |=> deepest_sleep_inhibit)
      else $error("Running playback did not inhibit the deepest state.");

   a_rec_inhibit: assert property (
      ce && enable_b_r[cbe_pkg::B_REC_INH] && audio_state.record_run |=> deepest_sleep_inhibit)
      else $error("Running record did not inhibit the deepest state.");

   a_inhibit_off: assert property (
      ce && !enable_b_r[cbe_pkg::B_PLAY_INH] && !enable_b_r[cbe_pkg::B_REC_INH]
      |=> !deepest_sleep_inhibit)
      else $error("Deepest-state inhibit raised with both options off.");

   a_reset_regs: assert property (
      $rose(presetn) |-> enable_a_r == cbe_pkg::RST_ENABLE_A
                         && enable_b_r == cbe_pkg::RST_ENABLE_B)
      else $error("Enable bytes not zero after reset.");

   a_reset_base: assert property (
      $rose(presetn) |-> wdt_mem_base == 32'h00000000)
      else $error("Watchdog base not zero after reset.");

   a_reset_outputs: assert property (
      $rose(presetn) |-> !cx_break_event && !all_bm_active && !audio_dma_active
                         && !bm_status_audio && !deepest_sleep_inhibit)
      else $error("Event outputs not low after reset.");

   a_ce_freeze: assert property (
      !ce |=> $stable(cx_break_event) && $stable(all_bm_active) && $stable(audio_dma_active)
              && $stable(enable_a_r) && $stable(enable_b_r) && $stable(wdt_mem_base))
      else $error("State changed while the clock enable was low.");

endmodule

////////////////////////////////////////////////////////////////////////////////
// One writable register byte; sharing it keeps every lane's reset and write alike.

module cbe_byte_lane #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] lane_r
);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lane_r <= RST_VAL;
      end else if (wr_en) begin
         lane_r <= wr_data;
      end
   end

endmodule

// [sim/cbe_far_side.sv]
// Far-side model: bus-master sources and audio state changing at random intervals.
module cbe_far_side (
   input  wire logic            pclk,
   input  wire logic            presetn,
   output cbe_pkg::cbe_src_s    src_active,
   output cbe_pkg::cbe_audio_s  audio_state
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 32'h0000E3CF;
   integer hold = 0;
   // Values hold for up to four cycles, so both brief and lasting activity is seen.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_active  <= 8'h00;
         audio_state <= 6'h00;
         hold        <= 0;
      end else if (hold == 0) begin
         src_active  <= 8'($random(seed));
         audio_state <= 6'($random(seed));
         hold        <= $unsigned($random(seed)) % 4;
      end else begin
         hold <= hold - 1;
      end
   end
endmodule

// [sim/test_cstate_break_event_enables.sv]
// Testbench for the break-event enable registers and their combining logic.
module test_cstate_break_event_enables;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, chk_on = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, wdt_mem_base, rd;
   logic [3:0]  pstrb = 4'hF;
   logic        pready, pslverr, err, cx_break_event, all_bm_active;
   logic        audio_dma_active, bm_status_audio, deepest_sleep_inhibit;
   logic [7:0]  m_a = 8'h00, m_b = 8'h00;
   logic [4:0]  exp_ev;
   integer      n_errors = 0, cmp_count = 0, seed = 32'h0000E3CF;
   cbe_pkg::cbe_src_s   src_active;
   cbe_pkg::cbe_audio_s audio_state;
   ////////////////////////////////////////////////////////////////////////////
   cbe_enables uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .src_active, .audio_state, .cx_break_event,
      .all_bm_active, .audio_dma_active, .bm_status_audio, .deepest_sleep_inhibit,
      .wdt_mem_base);
   cbe_far_side far (.pclk, .presetn, .src_active, .audio_state);
   initial forever #2 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   // Audio bits: 5 apic, 4 fifo, 3 play, 2 record, 1 pointer, 0 ring run.
   function automatic logic [4:0] ev(logic [7:0] a, logic [7:0] b, logic [7:0] s,
                                     logic [5:0] u);
      logic st, dma, brk;
      st  = a[0] & (b[3] & u[1] | b[2] & u[0] | b[1] & u[2] | b[0] & u[3]);
      dma = st | a[0] & (s[0] | b[6] & u[4]);
      brk = |(a[7:1] & s[7:1]) | dma;
      return {brk, brk | b[7] & u[5], dma, st, b[5] & u[3] | b[4] & u[2]};
   endfunction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) exp_ev <= 5'h00;
      else if (ce) exp_ev <= ev(m_a, m_b, src_active, audio_state);
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] want);
      cmp_count++;
      if (got !== want) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   always @(negedge pclk) begin
      if (chk_on) cmp({27'h0, cx_break_event, all_bm_active, audio_dma_active,
         bm_status_audio, deepest_sleep_inhibit}, {27'h0, exp_ev});
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      if (wr && err === 1'b0 && pstrb[0] && a == cbe_pkg::ADDR_ENABLE_A) m_a <= d[7:0];
      if (wr && err === 1'b0 && pstrb[0] && a == cbe_pkg::ADDR_ENABLE_B) m_b <= d[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      cmp(rd, e);
   endtask
   task automatic report_and_stop;
      $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      n_errors++;
      report_and_stop;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_on = 1'b1;
      rdchk(cbe_pkg::ADDR_ENABLE_A, 32'h00000000);
      rdchk(cbe_pkg::ADDR_ENABLE_B, 32'h00000000);
      rdchk(cbe_pkg::ADDR_WDT_BASE, 32'h00000000);
      apb(1'b1, 12'h3A4, 32'hFFFFFFFF);
      cmp({31'h0, err}, 32'h00000001);
      $display("Reset and unmapped test done");
      apb(1'b1, cbe_pkg::ADDR_WDT_BASE, 32'hFFFFFFFF);
      rdchk(cbe_pkg::ADDR_WDT_BASE, 32'hFFFFFF00);
      cmp(wdt_mem_base, 32'hFFFFFF00);
      pstrb <= 4'h2;
      apb(1'b1, cbe_pkg::ADDR_WDT_BASE, 32'h12345678);
      pstrb <= 4'hF;
      rdchk(cbe_pkg::ADDR_WDT_BASE, 32'hFFFF5600);
      $display("Watchdog base test done");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, cbe_pkg::ADDR_ENABLE_A, 32'h00000001 << i);
         rdchk(cbe_pkg::ADDR_ENABLE_A, 32'h00000001 << i);
         repeat (12) @(posedge pclk);
      end
      $display("Single source test done");
      // Clock-enable drops during event traffic check that frozen state stays frozen.
      repeat (40) begin
         apb(1'b1, cbe_pkg::ADDR_ENABLE_A, $random(seed));
         apb(1'b1, cbe_pkg::ADDR_ENABLE_B, $random(seed));
         rdchk(cbe_pkg::ADDR_ENABLE_B, {24'h0, m_b});
         repeat (16) begin
            @(posedge pclk);
            ce <= ($random(seed) & 3) != 0;
         end
         @(posedge pclk);
         ce <= 1'b1;
      end
      $display("Random enable test done");
      // A cleared lane zero strobe must leave an enable byte untouched.
      pstrb <= 4'hE;
      apb(1'b1, cbe_pkg::ADDR_ENABLE_A, ~{24'h0, m_a});
      pstrb <= 4'hF;
      rdchk(cbe_pkg::ADDR_ENABLE_A, {24'h0, m_a});
      // A reset in mid-run must clear bytes that now hold written values.
      presetn <= 1'b0;
      m_a <= 8'h00;
      m_b <= 8'h00;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(cbe_pkg::ADDR_ENABLE_A, 32'h00000000);
      rdchk(cbe_pkg::ADDR_ENABLE_B, 32'h00000000);
      rdchk(cbe_pkg::ADDR_WDT_BASE, 32'h00000000);
      cmp(wdt_mem_base, 32'h00000000);
      $display("Strobe and mid-run reset test done");
      report_and_stop;
   end
endmodule
